/* epec_pkg.sv */
/*
  Shared constants and types of the E1 performance-monitor counter bank.
  Assumes a 32-bit AXI4-Lite register bus and event pulses on aclk.
*/
package epec_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [11:0] IDX_PRBS_HIGH = 12'h90d;
  localparam logic [11:0] IDX_PRBS_LOW = 12'h90e;
  localparam logic [11:0] IDX_SLIP = 12'h90f;
  localparam logic [11:0] IDX_ZERO_HIGH = 12'h910;
  localparam logic [11:0] IDX_ZERO_LOW = 12'h911;
  localparam logic [11:0] IDX_FCS2 = 12'h91c;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h920;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h921;

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int WIDE_COUNT = 16;
  localparam int NARROW_COUNT = 8;
  localparam int NUM_EVENTS = 4;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [3:0] IRQ_STATUS_RESET = 4'h0;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

  // Status bit positions
  localparam int EV_PRBS = 0;
  localparam int EV_SLIP = 1;
  localparam int EV_ZERO = 2;
  localparam int EV_FCS2 = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic prbs_error;
    logic slip_repeat;
    logic slip_drop;
    logic zero_violation;
    logic fcs2_error;
  } epec_events_t;

  typedef enum logic [8:0] {
    REG_NONE = 9'h001,
    REG_PRBS_HIGH = 9'h002,
    REG_PRBS_LOW = 9'h004,
    REG_SLIP = 9'h008,
    REG_ZERO_HIGH = 9'h010,
    REG_ZERO_LOW = 9'h020,
    REG_FCS2 = 9'h040,
    REG_IRQ_STATUS = 9'h080,
    REG_IRQ_MASK = 9'h100
  } epec_reg_t;

endpackage

/* epec_counter.sv */
/*
  One clear-on-read event counter, 8 or 16 bits wide.
  Assumes read strobes are one-cycle pulses from the bus slave.
*/
`timescale 1ns/10ps
module epec_counter #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Event and read strobes
  input wire logic inc,
  input wire logic rd_high,
  input wire logic rd_low,
  // Byte views
  output logic [7:0] high_byte,
  output logic [7:0] low_byte
);
  import epec_pkg::*;

  generate
    if (WIDTH > NARROW_COUNT) begin : g_wide
      logic [WIDTH-1:0] count;
      logic [WIDTH-1:0] snap;
      logic armed;
      logic [WIDTH-1:0] inc_ext;

      assign inc_ext = {{(WIDTH-1){1'b0}}, inc};

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          count <= '0; // [RQ11]
          snap <= '0;
          armed <= 1'b0;
        end else if (rd_low && armed) begin
          // Remove only what was reported; events during the read survive
          count <= count - snap + inc_ext; // [RQ4] [RQ12]
          armed <= 1'b0;
        end else if (rd_high) begin
          snap <= count; // [RQ12]
          armed <= 1'b1;
          count <= count + inc_ext; // [RQ1] [RQ7]
        end else begin
          count <= count + inc_ext; // [RQ1] [RQ7]
        end
      end

      // Lower byte comes from the snapshot once the upper byte was read
      assign high_byte = count[15:8]; // [RQ2] [RQ8]
      assign low_byte = armed ? snap[7:0] : count[7:0]; // [RQ9] [RQ3]
    end else begin : g_narrow
      logic [7:0] count;

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          count <= COUNT_RESET; // [RQ11]
        end else if (rd_low) begin
          count <= {7'h00, inc}; // [RQ5] [RQ10]
        end else begin
          count <= count + {7'h00, inc}; // [RQ5] [RQ10]
        end
      end

      assign high_byte = 8'h00;
      assign low_byte = count;
    end
  endgenerate

endmodule

/* epec_irq.sv */
/*
  Sticky event status with write-one-to-clear, mask and interrupt level.
  Assumes clear and mask writes are one-cycle strobes.
*/
`timescale 1ns/10ps
module epec_irq #(
  parameter int N = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Events
  input wire logic [N-1:0] events,
  // Software access
  input wire logic clear_wr,
  input wire logic [N-1:0] clear_bits,
  input wire logic mask_wr,
  input wire logic [N-1:0] mask_bits,
  // State
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);
  import epec_pkg::*;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
    end else begin
      // Set wins over a clear in the same cycle
      status <= (status & ~(clear_wr ? clear_bits : '0)) | events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask <= '0;
    end else if (mask_wr) begin
      mask <= mask_bits;
    end
  end

  assign irq = |(status & mask);

endmodule

/* epec_top.sv */
/*
  E1 performance-monitor counter bank behind an AXI4-Lite slave.
  Assumes event pulses are one aclk cycle wide and come from logic on aclk.
*/
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
// Notes on behaviour
// RQ1: 16-bit PRBS error count, low byte clears
// RQ2: PRBS count upper byte in own register
// RQ3: Software reads upper byte before lower byte
// RQ4: Upper then lower read clears the count
// RQ5: 8-bit clear-on-read transmit slip counter
// RQ6: Frame repeat or drop counts one slip
// RQ7: 16-bit clear-on-read zero violation count
// RQ8: Zero violation upper byte holds bits 15..8
// RQ9: Lower byte registers hold bits 7..0
// RQ10: 8-bit clear-on-read LAPD 2 FCS errors
// RQ11: All counters zero after reset
// RQ12: Upper read snapshots low byte, keeps events
module epec_top #(
  parameter int ADDR_W = 14
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // Write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // Read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Event pulses from framer, slip buffer and LAPD controller
  input wire epec_pkg::epec_events_t events,
  // Interrupt
  output logic irq
);
  import epec_pkg::*;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic epec_reg_t decode(input logic [ADDR_W-1:0] addr);
    logic [11:0] idx;
    idx = 12'(addr >> 2);
    if (addr[1:0] != 2'h0) begin
      decode = REG_NONE;
    end else begin
      case (idx)
        IDX_PRBS_HIGH: decode = REG_PRBS_HIGH;
        IDX_PRBS_LOW: decode = REG_PRBS_LOW;
        IDX_SLIP: decode = REG_SLIP;
        IDX_ZERO_HIGH: decode = REG_ZERO_HIGH;
        IDX_ZERO_LOW: decode = REG_ZERO_LOW;
        IDX_FCS2: decode = REG_FCS2;
        IDX_IRQ_STATUS: decode = REG_IRQ_STATUS;
        IDX_IRQ_MASK: decode = REG_IRQ_MASK;
        default: decode = REG_NONE;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // Event conditioning
  // ---------------------------------------------------------------
  logic slip_event;
  logic [NUM_EVENTS-1:0] ev_vec;

  // A repeated or a dropped frame is one slip; both in the same cycle count as one
  assign slip_event = events.slip_repeat | events.slip_drop; // [RQ6]

  always_comb begin
    ev_vec = '0;
    ev_vec[EV_PRBS] = events.prbs_error;
    ev_vec[EV_SLIP] = slip_event;
    ev_vec[EV_ZERO] = events.zero_violation;
    ev_vec[EV_FCS2] = events.fcs2_error;
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  logic rd_take;
  epec_reg_t rd_sel;

  assign arready = !rvalid;
  assign rd_take = arvalid && arready;
  assign rd_sel = rd_take ? decode(araddr) : REG_NONE;

  // Counter read strobes, each one cycle at the address handshake
  logic rd_prbs_high;
  logic rd_prbs_low;
  logic rd_slip;
  logic rd_zero_high;
  logic rd_zero_low;
  logic rd_fcs2;

  assign rd_prbs_high = (rd_sel == REG_PRBS_HIGH);
  assign rd_prbs_low = (rd_sel == REG_PRBS_LOW);
  assign rd_slip = (rd_sel == REG_SLIP);
  assign rd_zero_high = (rd_sel == REG_ZERO_HIGH);
  assign rd_zero_low = (rd_sel == REG_ZERO_LOW);
  assign rd_fcs2 = (rd_sel == REG_FCS2);

  // ---------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------
  logic [7:0] prbs_hi;
  logic [7:0] prbs_lo;
  logic [7:0] zero_hi;
  logic [7:0] zero_lo;
  logic [7:0] slip_lo;
  logic [7:0] fcs2_lo;

  epec_counter #(.WIDTH(WIDE_COUNT)) u_prbs (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc(events.prbs_error), // [RQ1]
    .rd_high(rd_prbs_high), // [RQ2]
    .rd_low(rd_prbs_low),
    .high_byte(prbs_hi),
    .low_byte(prbs_lo)
  );

  epec_counter #(.WIDTH(WIDE_COUNT)) u_zero (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc(events.zero_violation), // [RQ7]
    .rd_high(rd_zero_high),
    .rd_low(rd_zero_low),
    .high_byte(zero_hi),
    .low_byte(zero_lo)
  );

  epec_counter #(.WIDTH(NARROW_COUNT)) u_slip (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc(slip_event), // [RQ5]
    .rd_high(1'b0),
    .rd_low(rd_slip),
    .high_byte(),
    .low_byte(slip_lo)
  );

  epec_counter #(.WIDTH(NARROW_COUNT)) u_fcs2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc(events.fcs2_error), // [RQ10]
    .rd_high(1'b0),
    .rd_low(rd_fcs2),
    .high_byte(),
    .low_byte(fcs2_lo)
  );

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  epec_reg_t wr_sel;

  // Address and data are taken in either order, one write at a time
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign wr_sel = wr_fire ? decode(aw_addr_q) : REG_NONE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // Counters ignore writes; only status and mask are writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= (wr_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  logic [NUM_EVENTS-1:0] irq_status;
  logic [NUM_EVENTS-1:0] irq_mask;
  logic byte0_wr;

  assign byte0_wr = w_strb_q[0];

  epec_irq #(.N(NUM_EVENTS)) u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .events(ev_vec),
    .clear_wr((wr_sel == REG_IRQ_STATUS) && byte0_wr),
    .clear_bits(w_data_q[NUM_EVENTS-1:0]),
    .mask_wr((wr_sel == REG_IRQ_MASK) && byte0_wr),
    .mask_bits(w_data_q[NUM_EVENTS-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    case (rd_sel)
      REG_PRBS_HIGH: rd_byte = prbs_hi; // [RQ2]
      REG_PRBS_LOW: rd_byte = prbs_lo; // [RQ9]
      REG_SLIP: rd_byte = slip_lo;
      REG_ZERO_HIGH: rd_byte = zero_hi; // [RQ8]
      REG_ZERO_LOW: rd_byte = zero_lo; // [RQ9]
      REG_FCS2: rd_byte = fcs2_lo;
      REG_IRQ_STATUS: rd_byte = {4'h0, irq_status};
      REG_IRQ_MASK: rd_byte = {4'h0, irq_mask};
      default: rd_byte = 8'h00;
    endcase
  end

  // Byte registers sit in the low lane; upper bits read as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid <= 1'b1;
      rdata <= {24'h000000, rd_byte};
      rresp <= (rd_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

/* epec_top_sva.sv */
/*
  Bus and reset checker for the performance-monitor counter bank.
  Bound to every epec_top instance; sees only its ports.
*/
`timescale 1ns/10ps
module epec_top_sva #(
  parameter int ADDR_W = 14
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Interrupt
  input wire logic irq
);
  import epec_pkg::*;
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_idle: assert property (
    $rose(aresetn) |-> !rvalid && !bvalid && !irq) else $error("busy after reset");
  a_rd_answer: assert property (
    arvalid && arready |=> rvalid) else $error("read answer late");
  a_rd_once: assert property (
    rvalid && rready |=> !rvalid) else $error("read answered twice");
  a_ar_blocked: assert property (
    rvalid |-> !arready) else $error("read taken while busy");
  a_rdata_upper: assert property (
    rvalid |-> rdata[31:8] == 24'h0) else $error("upper data bits set");
  a_slverr_zero: assert property (
    rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0) else $error("error read data");
  a_wr_answer: assert property (
    awvalid && awready && wvalid && wready |-> ##2 bvalid) else $error("write answer late");
  a_aw_blocked: assert property (
    bvalid |-> !awready && !wready) else $error("write taken while busy");

  // Main scenarios
  c_slverr: cover property (rvalid && rresp == RESP_SLVERR);
  c_wr_ok: cover property (bvalid && bresp == RESP_OKAY);
  c_irq: cover property (irq);
endmodule

bind epec_top epec_top_sva #(.ADDR_W(ADDR_W)) i_sva (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
  .rresp, .irq);

/* tb_top.sv */
/*
  Self-checking bench for the performance-monitor counter bank.
  Drives bus and event pulses itself; a software model gives expectations.
*/
`timescale 1ns/10ps
module tb_top;
  import epec_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
  logic arvalid = 0, arready, rvalid, rready = 0, irq;
  logic [13:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0] bresp, rresp, r;
  epec_events_t events = '0;
  logic [15:0] m_prbs = 0, m_zero = 0;
  logic [7:0] m_slip = 0, m_fcs = 0;
  logic [11:0] regs [6] = '{IDX_PRBS_HIGH, IDX_PRBS_LOW, IDX_SLIP, IDX_ZERO_HIGH,
    IDX_ZERO_LOW, IDX_FCS2};
  int seed = 32'h96df;
  int miscompares = 0, tests_run = 0, cycles = 0;

  always #4 aclk = ~aclk;

  epec_top i_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
    .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .events, .irq);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task chk(input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  function logic [33:0] ok8(input logic [7:0] b);
    return {RESP_OKAY, 24'h0, b};
  endfunction

  task rd(input logic [11:0] idx);
    @(posedge aclk);
    arvalid <= 1;
    araddr <= {idx, 2'b00};
    rready <= 1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 0;
    @(posedge aclk);
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask

  task rdc(input logic [11:0] idx, input logic [33:0] exp);
    rd(idx);
    chk({r, d}, exp);
  endtask

  task wr(input logic [11:0] idx, input logic [31:0] v);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    awvalid <= 1;
    wvalid <= 1;
    awaddr <= {idx, 2'b00};
    wdata <= v;
    bready <= 1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awready && !ta) begin
        ta = 1;
        awvalid <= 0;
      end
      if (wready && !tw) begin
        tw = 1;
        wvalid <= 0;
      end
    end
    @(posedge aclk);
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 0;
  endtask

  // Zero pattern means random events; model counts what is sent
  task run_ev(input int n, input logic [4:0] fix);
    epec_events_t e;
    repeat (n) begin
      @(posedge aclk);
      e = fix;
      if (fix == 5'h0) e = 5'($random(seed));
      events <= e;
      m_prbs = m_prbs + e.prbs_error;
      m_zero = m_zero + e.zero_violation;
      m_slip = m_slip + (e.slip_repeat | e.slip_drop);
      m_fcs = m_fcs + e.fcs2_error;
    end
    @(posedge aclk);
    events <= '0;
  endtask

  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Hang guard, well above the roughly one thousand cycles needed
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test;
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 6; i++) rdc(regs[i], ok8(8'h0));
    rdc(12'h123, {RESP_SLVERR, 32'h0});
    run_ev(700, 5'h0);
    rdc(IDX_PRBS_HIGH, ok8(m_prbs[15:8]));
    rdc(IDX_PRBS_LOW, ok8(m_prbs[7:0]));
    rdc(IDX_ZERO_HIGH, ok8(m_zero[15:8]));
    rdc(IDX_ZERO_LOW, ok8(m_zero[7:0]));
    rdc(IDX_SLIP, ok8(m_slip));
    rdc(IDX_FCS2, ok8(m_fcs));
    for (int i = 0; i < 6; i++) rdc(regs[i], ok8(8'h0));
    run_ev(3, 5'h02);
    rdc(IDX_ZERO_LOW, ok8(8'h3));
    rdc(IDX_ZERO_LOW, ok8(8'h3));
    rdc(IDX_ZERO_HIGH, ok8(8'h0));
    rdc(IDX_ZERO_LOW, ok8(8'h3));
    rdc(IDX_ZERO_LOW, ok8(8'h0));
    run_ev(5, 5'h10);
    rdc(IDX_PRBS_HIGH, ok8(8'h0));
    run_ev(2, 5'h10);
    rdc(IDX_PRBS_LOW, ok8(8'h5));
    rdc(IDX_PRBS_HIGH, ok8(8'h0));
    rdc(IDX_PRBS_LOW, ok8(8'h2));
    run_ev(4, 5'h0c);
    rdc(IDX_SLIP, ok8(8'h4));
    wr(IDX_FCS2, 32'hff);
    chk({r, 32'h0}, {RESP_OKAY, 32'h0});
    run_ev(1, 5'h01);
    rdc(IDX_FCS2, ok8(8'h1));
    wr(12'h3ff, 32'h1);
    chk({r, 32'h0}, {RESP_SLVERR, 32'h0});
    wr(IDX_IRQ_STATUS, 32'hf);
    wr(IDX_IRQ_MASK, 32'h1);
    chk(34'(irq), 34'h0);
    run_ev(1, 5'h10);
    @(posedge aclk);
    chk(34'(irq), 34'h1);
    rdc(IDX_IRQ_STATUS, ok8(8'h1));
    wr(IDX_IRQ_MASK, 32'h0);
    chk(34'(irq), 34'h0);
    wr(IDX_IRQ_STATUS, 32'h1);
    rdc(IDX_IRQ_STATUS, ok8(8'h0));
    stop_test;
  end
endmodule
